//--- ctec_defs.vh
// Constants for the charge-time edge-control block: register offsets,
// field positions, write masks, reset values and source codes.
// Assumes a byte-addressed register port with 32-bit words.
`ifndef CTEC_DEFS_VH
`define CTEC_DEFS_VH

`define CTEC_ADDR_W        8
`define CTEC_CTRL_OFS      8'h00
`define CTEC_STAT_OFS      8'h04

// Control register field positions
`define CTEC_E1STAT_BIT    24
`define CTEC_E2MODE_BIT    23
`define CTEC_E2POL_BIT     22
`define CTEC_E2SEL_HI      21
`define CTEC_E2SEL_LO      18
`define CTEC_ON_BIT        15
`define CTEC_IDLE_BIT      13
`define CTEC_TIME_GENERATION_ENABLE_BIT      12
`define CTEC_EDGE_ENABLE_BIT     11
`define CTEC_CTRL_WMASK    32'h01FCB800
`define CTEC_CTRL_RESET    32'h00000000

// Status register field positions
`define CTEC_S_E2STAT_BIT  0
`define CTEC_S_RUN_BIT     1
`define CTEC_S_IDLE_BIT    2

// Second-edge source codes
`define CTEC_SRC_RSVD      4'hF
`define CTEC_SRC_CMP2      4'hE
`define CTEC_SRC_CMP1      4'hD
`define CTEC_SRC_PERIPHERAL_BUS_CLOCK     4'hC
`define CTEC_SRC_CAP3      4'hB
`define CTEC_SRC_CAP2      4'hA
`define CTEC_SRC_CAP1      4'h9
`define CTEC_SRC_PIN13     4'h8
`define CTEC_SRC_PIN12     4'h7
`define CTEC_SRC_PIN11     4'h6
`define CTEC_SRC_PIN10     4'h5
`define CTEC_SRC_PIN9      4'h4
`define CTEC_SRC_PIN1      4'h3
`define CTEC_SRC_PIN2      4'h2
`define CTEC_SRC_OC1       4'h1
`define CTEC_SRC_TMR1      4'h0

`define CTEC_SYNC_STAGES   2

`endif

//--- ctec_edge_qual.v
// Edge or level qualifier for one already-synchronous source.
// Assumes the caller gates the result with its own enables.
`timescale 1ns/1ps
module ctec_edge_qual (
   input  wire clk,        // Block clock
   input  wire rst,        // Synchronous reset, active high
   input  wire sig,        // Synchronous source level
   input  wire edge_mode,  // 1 edge-sensitive, 0 level-sensitive
   input  wire polarity,   // 1 rising / high, 0 falling / low
   output reg  evt_q       // Qualified event, registered
);
   reg  prev_q;
   wire active;
   wire rise;
   wire fall;
   wire evt_d;

   // Level match and transition terms
   assign active = polarity ? sig : ~sig;
   assign rise   = sig & ~prev_q;
   assign fall   = ~sig & prev_q;
   assign evt_d  = edge_mode ? (polarity ? rise : fall)
                             : active;

   // Previous level and registered event
   always @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b0;
         evt_q  <= 1'b0;
      end else begin
         prev_q <= sig;
         evt_q  <= evt_d;
      end
   end
endmodule

//--- ctec_top.v
// Edge-control logic of the charge-time measurement unit: control
// and status registers, source selection, synchronisers and gating.
// Assumes a single clock, a plain strobe register port and event
// inputs that are single-cycle pulses in the same clock domain.
`timescale 1ns/1ps
`include "ctec_defs.vh"
module ctec_top #(
   parameter PIN_COUNT = 13      // External edge pins 1..13
) (
   input  wire                    REF_CLK,       // Block clock, 100 MHz
   input  wire                    SYS_RST,       // Synchronous reset, high
   input  wire [`CTEC_ADDR_W-1:0] ADDR,          // Register byte address
   input  wire [31:0]             WR_DATA,       // Write data
   input  wire                    WR_STB,        // Write strobe
   input  wire                    RD_STB,        // Read strobe
   output reg  [31:0]             RD_DATA,       // Read data, next cycle
   input  wire                    IDLE_MODE,     // Chip is in idle mode
   input  wire                    EDGE_ONE_SRC,  // First-edge source level
   input  wire [PIN_COUNT-1:0]    EXT_EDGE_PINS, // External edge pins
   input  wire                    CMP_ONE_OUT,   // Comparator 1 output
   input  wire                    CMP_TWO_OUT,   // Comparator 2 output
   input  wire [2:0]              CAPTURE_EVT,   // Capture units 3..1
   input  wire                    OC_ONE_EVT,    // Output compare 1 event
   input  wire                    TIMER_ONE_EVT, // Timer 1 event
   output reg                     EDGE1_EVENT,   // Passed first-edge pulse
   output reg                     EDGE2_EVENT,   // Passed second-edge pulse
   output reg                     EDGE1_STATUS,  // First-edge status flag
   output reg                     EDGE2_STATUS,  // Second-edge status flag
   output reg                     MODULE_RUN,    // Edge logic is running
   output reg                     DELAY_GEN_EN   // Delay generation active
);
   localparam NSYNC = PIN_COUNT + 3;   // Pins, two comparators, edge 1

   // Control fields
   reg        e1stat_q;
   reg        e2mode_q;
   reg        e2pol_q;
   reg  [3:0] e2sel_q;
   reg        on_q;
   reg        idle_stop_q;
   reg        time_generation_enable_q;
   reg        edge_enable_q;
   reg        e2stat_q;

   // Bus and read path
   reg  [31:0] rd_d;
   wire [31:0] ctrl_rd;
   wire [31:0] stat_rd;
   wire        ctrl_wr;
   wire        stat_wr;
   wire [31:0] wr_m;

   // Synchronisers and sources
   reg  [NSYNC-1:0] sync1_q;
   reg  [NSYNC-1:0] sync2_q;
   wire [NSYNC-1:0] raw_in;
   wire [PIN_COUNT-1:0] pin_s;
   wire        cmp1_s;
   wire        cmp2_s;
   wire        e1_s;
   reg         peripheral_bus_clock_q;
   reg         src2;

   // Qualified and gated events
   wire        e1_evt;
   wire        e2_evt;
   wire        running;
   wire        idle_hold;
   wire        pass;
   wire        e1_pass;
   wire        e2_pass;

   // Register map, one 32-bit word per byte offset
   //   0x00 control
   //     bit 24      first-edge flag, set by hardware, written by software
   //     bit 23      second edge: 1 edge, 0 level sensing
   //     bit 22      second edge: 1 rising or high, 0 falling or low
   //     bits 21:18  second-edge source code
   //     bits 17:16  always zero
   //     bit 15      module enable
   //     bit 14      always zero
   //     bit 13      stop while the chip idles
   //     bit 12      delay generation enable
   //     bit 11      edge enable; clear blocks every edge
   //     others      always zero
   //   0x04 status
   //     bit 0       second-edge flag, write one to clear
   //     bit 1       edge logic running, read only
   //     bit 2       suspended by idle, read only
   //     others      always zero
   //   Other offsets ignore writes and read zero
   //   Every stored bit resets to zero
   //   A same-cycle set beats a software clear on both flags

   // Address decode; unmapped addresses ignore writes, read zero.
   // Only the documented bits are stored; the write mask drops the rest.
   assign ctrl_wr = WR_STB & (ADDR == `CTEC_CTRL_OFS);
   assign stat_wr = WR_STB & (ADDR == `CTEC_STAT_OFS);
   assign wr_m    = WR_DATA & `CTEC_CTRL_WMASK;

   // Run state: enable bit and idle suspension.
   // Idle gates the enable rather than clearing it, so the module
   // resumes on wake-up without software writing it again.
   assign idle_hold = idle_stop_q & IDLE_MODE;
   assign running   = on_q & ~idle_hold;
   assign pass      = running & edge_enable_q;
   assign e1_pass   = pass & e1_evt;
   assign e2_pass   = pass & e2_evt;

   // Control register image; unlisted bits read zero
   assign ctrl_rd = {7'h0,
                     e1stat_q,
                     e2mode_q,
                     e2pol_q,
                     e2sel_q,
                     2'h0,
                     on_q,
                     1'b0,
                     idle_stop_q,
                     time_generation_enable_q,
                     edge_enable_q,
                     11'h0};

   // Status register image
   assign stat_rd = {29'h0000000, idle_hold, running, e2stat_q};

   // Control register: writes and hardware-set first-edge flag.
   // A write loads every field at once; partial updates need a read first.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         e1stat_q    <= 1'b0;
         e2mode_q    <= 1'b0;
         e2pol_q     <= 1'b0;
         e2sel_q     <= 4'h0;
         on_q        <= 1'b0;
         idle_stop_q <= 1'b0;
         time_generation_enable_q      <= 1'b0;
         edge_enable_q     <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            e2mode_q    <= wr_m[`CTEC_E2MODE_BIT];
            e2pol_q     <= wr_m[`CTEC_E2POL_BIT];
            e2sel_q     <= wr_m[`CTEC_E2SEL_HI:`CTEC_E2SEL_LO];
            on_q        <= wr_m[`CTEC_ON_BIT];
            idle_stop_q <= wr_m[`CTEC_IDLE_BIT];
            time_generation_enable_q      <= wr_m[`CTEC_TIME_GENERATION_ENABLE_BIT];
            edge_enable_q     <= wr_m[`CTEC_EDGE_ENABLE_BIT];
         end
         // A qualifying edge wins over a software clear
         if (e1_pass)
            e1stat_q <= 1'b1;
         else if (ctrl_wr)
            e1stat_q <= wr_m[`CTEC_E1STAT_BIT];
      end
   end

   // Second-edge status: set by hardware, write one to clear.
   // Writing zeros back in a read-modify-write leaves the flag alone.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         e2stat_q <= 1'b0;
      end else if (e2_pass) begin
         e2stat_q <= 1'b1;
      end else if (stat_wr & WR_DATA[`CTEC_S_E2STAT_BIT]) begin
         e2stat_q <= 1'b0;
      end
   end

   // Read mux; data stand only in the cycle after the strobe.
   // Returning to zero keeps a late sample from seeing stale data.
   always @* begin
      rd_d = 32'h00000000;
      if (RD_STB) begin
         case (ADDR)
            `CTEC_CTRL_OFS: rd_d = ctrl_rd;
            `CTEC_STAT_OFS: rd_d = stat_rd;
            default:        rd_d = 32'h00000000;
         endcase
      end
   end

   always @(posedge REF_CLK) begin
      if (SYS_RST)
         RD_DATA <= 32'h00000000;
      else
         RD_DATA <= rd_d;
   end

   // Latency seen from a pin: two synchroniser stages, one qualifier
   // stage and the output register, so a change in cycle 0 shows on
   // the event output after edge 4. Internal event lines skip the
   // synchronisers and show after edge 2. A pin pulse shorter than
   // one clock may be missed; pins must hold each level a full cycle.
   // Reset clears both stages; one cycle of reset flushes them.
   // Two-stage synchronisers; the first stage feeds only the second
   assign raw_in = {EDGE_ONE_SRC, CMP_TWO_OUT, CMP_ONE_OUT, EXT_EDGE_PINS};

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         sync1_q <= {NSYNC{1'b0}};
         sync2_q <= {NSYNC{1'b0}};
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   assign pin_s  = sync2_q[PIN_COUNT-1:0];
   assign cmp1_s = sync2_q[PIN_COUNT];
   assign cmp2_s = sync2_q[PIN_COUNT+1];
   assign e1_s   = sync2_q[PIN_COUNT+2];

   // Bus clock as a source: a level that changes on every edge,
   // since the clock itself cannot be sampled as data;
   // the toggle gives one rising edge every two cycles
   always @(posedge REF_CLK) begin
      if (SYS_RST)
         peripheral_bus_clock_q <= 1'b0;
      else
         peripheral_bus_clock_q <= ~peripheral_bus_clock_q;
   end

   // Second-edge source selector. Code 1111 is reserved and picks a
   // constant low, so a stray write cannot raise spurious edges.
   // Comparator and pin levels come through the synchronisers;
   // capture, compare and timer events are already in this domain.
   always @* begin
      case (e2sel_q)
         `CTEC_SRC_RSVD:  src2 = 1'b0;
         `CTEC_SRC_CMP2:  src2 = cmp2_s;
         `CTEC_SRC_CMP1:  src2 = cmp1_s;
         `CTEC_SRC_PERIPHERAL_BUS_CLOCK: src2 = peripheral_bus_clock_q;
         `CTEC_SRC_CAP3:  src2 = CAPTURE_EVT[2];
         `CTEC_SRC_CAP2:  src2 = CAPTURE_EVT[1];
         `CTEC_SRC_CAP1:  src2 = CAPTURE_EVT[0];
         `CTEC_SRC_PIN13: src2 = pin_s[12];
         `CTEC_SRC_PIN12: src2 = pin_s[11];
         `CTEC_SRC_PIN11: src2 = pin_s[10];
         `CTEC_SRC_PIN10: src2 = pin_s[9];
         `CTEC_SRC_PIN9:  src2 = pin_s[8];
         `CTEC_SRC_PIN1:  src2 = pin_s[0];
         `CTEC_SRC_PIN2:  src2 = pin_s[1];
         `CTEC_SRC_OC1:   src2 = OC_ONE_EVT;
         `CTEC_SRC_TMR1:  src2 = TIMER_ONE_EVT;
         default:         src2 = 1'b0;
      endcase
   end

   // First edge: rising, edge-sensitive; its own select lies elsewhere.
   // Its flag is the only hardware-set bit in the control word.
   ctec_edge_qual u_edge1 (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .sig       (e1_s),
      .edge_mode (1'b1),
      .polarity  (1'b1),
      .evt_q     (e1_evt)
   );

   // Second edge: mode and polarity from the control register.
   // They apply at once, so changing them may raise one event.
   ctec_edge_qual u_edge2 (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .sig       (src2),
      .edge_mode (e2mode_q),
      .polarity  (e2pol_q),
      .evt_q     (e2_evt)
   );

   // Event outputs; blocked edges never reach the measurement.
   // Level mode keeps the event high while the level matches.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         EDGE1_EVENT <= 1'b0;
         EDGE2_EVENT <= 1'b0;
      end else begin
         EDGE1_EVENT <= e1_pass;
         EDGE2_EVENT <= e2_pass;
      end
   end

   // Flag copies; one cycle behind the register bits
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         EDGE1_STATUS <= 1'b0;
         EDGE2_STATUS <= 1'b0;
      end else begin
         EDGE1_STATUS <= e1stat_q;
         EDGE2_STATUS <= e2stat_q;
      end
   end

   // Run and delay state for the current-source side
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         MODULE_RUN   <= 1'b0;
         DELAY_GEN_EN <= 1'b0;
      end else begin
         MODULE_RUN   <= running;
         // Delay generation trusts software to pick comparator 2
         DELAY_GEN_EN <= running & time_generation_enable_q;
      end
   end
endmodule

//--- ctec_chk_sva.sv
// Checker for the edge-control block top.
// Assumes control at 0x00 and status at 0x04.
`timescale 1ns/1ps
`include "ctec_defs.vh"
module ctec_chk (
   input wire                    REF_CLK,      // Clock
   input wire                    SYS_RST,      // Reset
   input wire [`CTEC_ADDR_W-1:0] ADDR,         // Address
   input wire [31:0]             WR_DATA,      // Write data
   input wire                    WR_STB,       // Write strobe
   input wire                    RD_STB,       // Read strobe
   input wire [31:0]             RD_DATA,      // Read data
   input wire                    IDLE_MODE,    // Idle
   input wire                    EDGE1_EVENT,  // Edge 1 pulse
   input wire                    EDGE2_EVENT,  // Edge 2 pulse
   input wire                    EDGE1_STATUS, // Edge 1 flag
   input wire                    EDGE2_STATUS, // Edge 2 flag
   input wire                    MODULE_RUN,   // Running
   input wire                    DELAY_GEN_EN  // Delay gen
);
   reg [31:0] ctl_q;
   reg [2:0]  blk_q;
   wire       ctl_wr = WR_STB && ADDR == `CTEC_CTRL_OFS;
   wire       st_clr = WR_STB && ADDR == `CTEC_STAT_OFS && WR_DATA[0];
   wire       idl = ctl_q[13] && IDLE_MODE;
   // Shadow of software bits; counter of blocked cycles
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctl_q <= 32'h00000000;
         blk_q <= 3'h0;
      end else begin
         if (ctl_wr)
            ctl_q <= WR_DATA & 32'h00FCB800;
         blk_q <= (ctl_q[15] && ctl_q[11]) ? 3'h0 : blk_q + {2'h0, blk_q != 3'h7};
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   rd_idle_a: assert property (!$past(RD_STB) |-> RD_DATA == 32'h00000000)
      else $error("read data not idle");
   rsvd_zero_a: assert property ($past(ctl_wr) || !$past(RD_STB && ADDR == `CTEC_CTRL_OFS)
      || (RD_DATA & 32'hFE034000) == 32'h00000000) else $error("reserved bit set");
   ctl_back_a: assert property ($past(RD_STB && ADDR == `CTEC_CTRL_OFS)
      |-> RD_DATA[23:11] == $past(ctl_q[23:11])) else $error("control readback");
   run_off_a: assert property (!$past(ctl_q[15]) |-> !MODULE_RUN)
      else $error("run while off");
   run_on_a: assert property ((ctl_q[15] && !idl)[*3] |-> MODULE_RUN)
      else $error("not running");
   idle_stop_a: assert property (idl[*3] |-> !MODULE_RUN) else $error("runs in idle");
   dgen_on_a: assert property ((ctl_q[15] && ctl_q[12] && !idl)[*3] |-> DELAY_GEN_EN)
      else $error("delay gen off");
   dgen_off_a: assert property (!$past(ctl_q[12]) |-> !DELAY_GEN_EN)
      else $error("delay gen on");
   edge_block_a: assert property (blk_q == 3'h7 |-> !EDGE1_EVENT && !EDGE2_EVENT)
      else $error("edge passed while blocked");
   flag2_hold_a: assert property ($fell(EDGE2_STATUS) |-> $past(st_clr, 2))
      else $error("edge 2 flag lost");
   flag1_hold_a: assert property ($fell(EDGE1_STATUS) |-> $past(ctl_wr && !WR_DATA[24], 2))
      else $error("edge 1 flag lost");
   flag2_set_a: assert property (EDGE2_EVENT |=> EDGE2_STATUS) else $error("no flag 2");
   flag1_set_a: assert property (EDGE1_EVENT |=> EDGE1_STATUS) else $error("no flag 1");
   cover property (EDGE2_EVENT [*3]);
   cover property ($fell(EDGE2_STATUS));
   cover property (DELAY_GEN_EN);
endmodule
bind ctec_top ctec_chk u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
   .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
   .IDLE_MODE(IDLE_MODE), .EDGE1_EVENT(EDGE1_EVENT), .EDGE2_EVENT(EDGE2_EVENT),
   .EDGE1_STATUS(EDGE1_STATUS), .EDGE2_STATUS(EDGE2_STATUS),
   .MODULE_RUN(MODULE_RUN), .DELAY_GEN_EN(DELAY_GEN_EN));

//--- ctec_src_model.sv
// Model of the edge sources: pins, comparators and event lines.
// Assumes the bench names one source and asks it to fire.
`timescale 1ns/1ps
module ctec_src_model (
   input  wire        clk,  // Clock
   input  wire [3:0]  code, // Source to move
   input  wire        pol,  // Active level
   input  wire        fire, // Fire, level
   output reg  [12:0] pins, // Edge pins
   output reg         cmp1, // Comparator 1
   output reg         cmp2, // Comparator 2
   output reg  [2:0]  cap,  // Captures
   output reg         oc1,  // Compare event
   output reg         tmr1  // Timer event
);
   reg  fire_q = 1'b0;
   wire lvl = fire ^ ~pol;           // Idles at the inactive level
   wire evt = (fire & ~fire_q) ^ ~pol; // Events last one cycle
   always @(posedge clk) fire_q <= fire;
   // Only the named source moves, so a wrong select sees nothing
   always @* begin
      {pins, cmp1, cmp2, cap, oc1, tmr1} = 20'h00000;
      case (code)
         4'h0: tmr1 = evt;
         4'h1: oc1 = evt;
         4'h2: pins[1] = lvl;
         4'h3: pins[0] = lvl;
         4'h4, 4'h5, 4'h6, 4'h7, 4'h8: pins[code + 4'h4] = lvl;
         4'h9, 4'hA, 4'hB: cap[code - 4'h9] = evt;
         4'hD: cmp1 = lvl;
         4'hE: cmp2 = lvl;
         default: ;
      endcase
   end
endmodule

//--- tb_top.sv
// Bench for the edge-control block; read answers checked from a queue.
// Assumes the source model drives all edge inputs but edge one.
`timescale 1ns/1ps
`include "ctec_defs.vh"
module tb_top;
   reg         REF_CLK = 1'b0;
   reg         SYS_RST = 1'b1;
   reg  [7:0]  ADDR = 8'h00;
   reg  [31:0] WR_DATA = 32'h00000000;
   reg         WR_STB = 1'b0;
   reg         RD_STB = 1'b0;
   reg         IDLE_MODE = 1'b0;
   reg         EDGE_ONE_SRC = 1'b0;
   reg  [3:0]  src_code = 4'h0;
   reg         src_pol = 1'b1;
   reg         src_fire = 1'b0;
   reg         rd_q = 1'b0;
   reg         p;
   reg  [31:0] exp_q [$];
   wire [31:0] RD_DATA;
   wire [12:0] pins;
   wire [2:0]  cap;
   wire        cmp1, cmp2, oc1, tmr1, EDGE2_EVENT, EDGE1_STATUS, DELAY_GEN_EN;
   wire        EDGE1_EVENT, EDGE2_STATUS, MODULE_RUN;
   integer     seed = 94, n_mismatch = 0, compares = 0, cyc = 0, i, r;
   ctec_top dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .IDLE_MODE(IDLE_MODE),
      .EDGE_ONE_SRC(EDGE_ONE_SRC), .EXT_EDGE_PINS(pins), .CMP_ONE_OUT(cmp1),
      .CMP_TWO_OUT(cmp2), .CAPTURE_EVT(cap), .OC_ONE_EVT(oc1), .TIMER_ONE_EVT(tmr1),
      .EDGE1_EVENT(EDGE1_EVENT), .EDGE2_EVENT(EDGE2_EVENT), .EDGE1_STATUS(EDGE1_STATUS),
      .EDGE2_STATUS(EDGE2_STATUS), .MODULE_RUN(MODULE_RUN), .DELAY_GEN_EN(DELAY_GEN_EN));
   ctec_src_model u_src (.clk(REF_CLK), .code(src_code), .pol(src_pol), .fire(src_fire),
      .pins(pins), .cmp1(cmp1), .cmp2(cmp2), .cap(cap), .oc1(oc1), .tmr1(tmr1));
   initial forever #5 REF_CLK = ~REF_CLK;
   task results;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge REF_CLK) {WR_STB, ADDR, WR_DATA} <= {1'b1, a, d};
         @(posedge REF_CLK) WR_STB <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge REF_CLK) {RD_STB, ADDR} <= {1'b1, a};
         exp_q.push_back(e);
         @(posedge REF_CLK) RD_STB <= 1'b0;
      end
   endtask
   // Arm one source, clear the flag, fire, then time the passed event
   task try(input [3:0] c, input pl, input [31:0] cfg, input [31:0] base, input f,
            input integer lat_e, input integer hi_e);
      integer k, lat, hi;
      begin
         lat = 0;
         hi = 0;
         @(posedge REF_CLK) {src_code, src_pol, src_fire} <= {c, pl, 1'b0};
         repeat (6) @(posedge REF_CLK);
         wr(`CTEC_CTRL_OFS, cfg | {pl, c, 18'h0});
         wr(`CTEC_STAT_OFS, 32'h00000001);
         rd(`CTEC_STAT_OFS, base | (f && c == 4'hC));
         @(posedge REF_CLK) src_fire <= 1'b1;
         for (k = 1; k <= 10; k = k + 1) begin
            @(posedge REF_CLK) #1;
            hi = hi + (EDGE2_EVENT === 1'b1);
            if (EDGE2_EVENT === 1'b1 && lat == 0)
               lat = k;
         end
         chk("MODULE_RUN", MODULE_RUN, base[1]);
         chk("EDGE2_STATUS", EDGE2_STATUS, f);
         @(posedge REF_CLK) src_fire <= 1'b0;
         rd(`CTEC_STAT_OFS, base | f);
         if (c != 4'hC) begin
            chk("latency", lat, lat_e);
            chk("high cycles", hi, hi_e);
         end
      end
   endtask
   // Each read answer is matched to the oldest note; hang guard
   always @(posedge REF_CLK) begin
      rd_q <= RD_STB;
      if (rd_q)
         chk("RD_DATA", RD_DATA, exp_q.pop_front());
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         results;
      end
   end
   initial begin
      repeat (4) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      rd(`CTEC_CTRL_OFS, 32'h00000000);
      rd(`CTEC_STAT_OFS, 32'h00000000);
      r = $random(seed);
      wr({r[7:4], 4'h8}, 32'hFFFFFFFF);
      rd({r[7:4], 4'h8}, 32'h00000000);
      // All ones but source 1111: delay generation wants comparator 2
      wr(`CTEC_CTRL_OFS, 32'hFFFBFFFF);
      rd(`CTEC_CTRL_OFS, `CTEC_CTRL_WMASK & 32'hFFFBFFFF);
      // Converter discharge lies outside the block; never requested here
      #1 chk("DELAY_GEN_EN", DELAY_GEN_EN, 1);
      wr(`CTEC_CTRL_OFS, 32'h00000000);
      rd(`CTEC_CTRL_OFS, 32'h00000000);
      wr(`CTEC_CTRL_OFS, 32'h00008800);
      @(posedge REF_CLK) EDGE_ONE_SRC <= 1'b1;
      repeat (4) @(posedge REF_CLK);
      #1 chk("EDGE1_EVENT", EDGE1_EVENT, 1);
      repeat (4) @(posedge REF_CLK);
      #1 chk("EDGE1_STATUS", EDGE1_STATUS, 1);
      rd(`CTEC_CTRL_OFS, 32'h01008800);
      EDGE_ONE_SRC <= 1'b0;
      $display("register test done");
      for (i = 0; i < 16; i = i + 1) begin
         r = $random(seed);
         p = r[0];
         try(i, p, 32'h00808800, 32'h2, i != 15, i == 15 ? 0 :
             (i < 2 || (i > 8 && i < 12)) ? 2 : 4, i != 15);
      end
      try(4'h3, 1'b1, 32'h00808000, 32'h2, 1'b0, 0, 0);
      try(4'h3, 1'b1, 32'h00800800, 32'h0, 1'b0, 0, 0);
      IDLE_MODE <= 1'b1;
      try(4'h3, 1'b1, 32'h0080A800, 32'h4, 1'b0, 0, 0);
      try(4'h3, 1'b1, 32'h00808800, 32'h2, 1'b1, 4, 1);
      IDLE_MODE <= 1'b0;
      try(4'h3, 1'b1, 32'h00008800, 32'h2, 1'b1, 4, 7);
      $display("source test done");
      results;
   end
endmodule
